/* hw/ssb_exec_map.vh */
// Purpose: constants for the stack, byte-swap and arithmetic executor
// Assumes: byte addresses on the software port, word aligned
// Notes: flag bits sit in the low nibble of the flags register
`ifndef SSB_EXEC_MAP_VH
`define SSB_EXEC_MAP_VH

// ****************************************
// software port offsets
// ****************************************
`define SSB_OFF_LOW0 8'h00
`define SSB_OFF_SP 8'h20
`define SSB_OFF_LINK 8'h24
`define SSB_OFF_PC 8'h28
`define SSB_OFF_FLAGS 8'h2c
`define SSB_OFF_STAT 8'h30
`define SSB_OFF_CLR 8'h34
`define SSB_OFF_EN 8'h38

// ****************************************
// fields and reset values
// ****************************************
`define SSB_FLG_N 3
`define SSB_FLG_Z 2
`define SSB_FLG_C 1
`define SSB_FLG_V 0
`define SSB_ST_DONE 0
`define SSB_ST_FAULT 1
`define SSB_ST_EMPTY 2
`define SSB_ST_BRANCH 3
`define SSB_RST_WORD 32'h0000_0000
`define SSB_WORD_STEP 32'h0000_0004
`define SSB_IDX_PC 4'hf
`define SSB_IDX_LINK 4'he

// ****************************************
// encodings
// ****************************************
`define SSB_OP_POP 7'h5e
`define SSB_OP_PUSH 7'h5a
`define SSB_OP_WSWAP 10'h2e8
`define SSB_OP_HSWAP 10'h2e9
`define SSB_OP_SSWAP 10'h2eb
`define SSB_OP_ROTR 10'h107
`define SSB_OP_RSUB 10'h109
`define SSB_OP_SUBC 10'h106

`endif

/* hw/ssb_exec.v */
// Purpose: decode and execute pop, push, byte swaps, rotate, reverse
//          subtract and subtract with carry
// Assumes: stack memory returns read data the cycle after mem_rd
// Notes: software port reads answer one cycle after sw_rd
//
// Contract
// - pop mask: select bit, seven zeros, low list
// - pop ascending from stack pointer, pointer rises
// - popped pc word bit0 zero faults
// - push mask: zero, link bit, zeros, list
// - push ascending from lowered pointer
// - word byte swap fully reverses bytes
// - halfword swap exchanges bytes per halfword
// - signed halfword swap then sign extend
// - rotate amount from bottom byte only
// - rotate sets n z c, keeps v
// - no flag update inside conditional block
// - reverse subtract: inverted source plus one
// - subtract with carry: a plus not b plus c
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "ssb_exec_map.vh"

module ssb_exec (
    // clock and reset
    input wire clk,
    input wire reset,
    // instruction issue
    input wire instr_valid,
    input wire [15:0] instr,
    input wire instr_in_cblock,
    output wire instr_ready,
    // stack memory
    output wire [31:0] mem_addr,
    output wire mem_rd,
    output wire mem_wr,
    output wire [31:0] mem_wdata,
    input wire [31:0] mem_rdata,
    // processor events
    output wire branch_valid,
    output wire [31:0] branch_target,
    output wire hard_fault,
    output wire busy,
    // software port
    input wire [7:0] sw_addr,
    input wire [31:0] sw_wdata,
    input wire sw_wr,
    input wire sw_rd,
    output wire [31:0] sw_rdata,
    output wire irq
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_RD = 2'h1;
    localparam [1:0] S_CAP = 2'h2;
    localparam [1:0] S_WR = 2'h3;

    // ****************************************
    // helpers
    // ****************************************
    function [3:0] lowest_idx;
        input [15:0] m;
        integer i;
        begin
            lowest_idx = 4'h0;
            for (i = 15; i >= 0; i = i - 1)
            begin
                if (m[i])
                    lowest_idx = i[3:0];
            end
        end
    endfunction

    function [4:0] bit_count;
        input [15:0] m;
        integer i;
        begin
            bit_count = 5'h00;
            for (i = 0; i < 16; i = i + 1)
                bit_count = bit_count + {4'h0, m[i]};
        end
    endfunction

    // returns {carry, overflow, sum}
    function [33:0] add_carry;
        input [31:0] a;
        input [31:0] b;
        input cin;
        reg [32:0] s;
        begin
            s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
            add_carry = {s[32], (a[31] == b[31]) && (s[31] != a[31]), s[31:0]};
        end
    endfunction

    function [31:0] rot_right;
        input [31:0] v;
        input [4:0] n;
        reg [63:0] d;
        begin
            d = {v, v} >> n;
            rot_right = d[31:0];
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    reg [31:0] low_r [0:7];
    reg [31:0] sp_r;
    reg [31:0] link_r;
    reg [31:0] pc_r;
    reg [3:0] flags_r;
    reg [1:0] state_r;
    reg [15:0] mask_r;
    reg [31:0] addr_r;
    reg [31:0] sp_end_r;
    reg [31:0] wdata_r;
    reg branch_r;
    reg fault_r;
    reg [3:0] status_r;
    reg [3:0] enable_r;
    reg [31:0] rdata_r;
    integer k;

    wire [2:0] rd_idx = instr[2:0];
    wire [2:0] rm_idx = instr[5:3];
    wire [31:0] op_d = low_r[rd_idx];
    wire [31:0] op_m = low_r[rm_idx];
    wire take = instr_valid && (state_r == S_IDLE);
    wire is_pop = instr[15:9] == `SSB_OP_POP;
    wire is_push = instr[15:9] == `SSB_OP_PUSH;
    wire [9:0] op10 = instr[15:6];
    wire set_flags;

    wire [15:0] pop_mask = {instr[8], 7'h00, instr[7:0]};
    wire [15:0] push_mask = {1'b0, instr[8], 6'h00, instr[7:0]};
    wire [15:0] start_mask = is_pop ? pop_mask : push_mask;
    wire [4:0] start_cnt = bit_count(start_mask);
    wire [31:0] span = {25'h0, start_cnt, 2'b00};

    assign set_flags = !instr_in_cblock;

    // ****************************************
    // single-cycle datapaths
    // ****************************************
    reg [31:0] alu_res;
    reg [3:0] alu_flags;
    reg alu_hit;
    reg [33:0] acv;
    reg [31:0] rot_v;

    always @*
    begin
        alu_res = op_d;
        alu_flags = flags_r;
        alu_hit = 1'b1;
        acv = 34'h0;
        rot_v = rot_right(op_d, op_m[4:0]);
        case (op10)
            `SSB_OP_WSWAP:
                alu_res = {op_m[7:0], op_m[15:8], op_m[23:16], op_m[31:24]};
            `SSB_OP_HSWAP:
                alu_res = {op_m[23:16], op_m[31:24], op_m[7:0], op_m[15:8]};
            `SSB_OP_SSWAP:
                alu_res = {{16{op_m[7]}}, op_m[7:0], op_m[15:8]};
            `SSB_OP_ROTR:
            begin
                if (op_m[7:0] != 8'h00)
                begin
                    alu_res = rot_v;
                    alu_flags[`SSB_FLG_C] = rot_v[31];
                end
                else
                begin
                    alu_res = op_d;
                end
                alu_flags[`SSB_FLG_N] = alu_res[31];
                alu_flags[`SSB_FLG_Z] = alu_res == 32'h0;
            end
            `SSB_OP_RSUB:
            begin
                // not source plus zero plus one
                acv = add_carry(~low_r[rm_idx], 32'h0, 1'b1);
                alu_res = acv[31:0];
                alu_flags = {acv[31], acv[31:0] == 32'h0, acv[33], acv[32]};
            end
            `SSB_OP_SUBC:
            begin
                // first plus not second plus carry
                acv = add_carry(op_d, ~op_m, flags_r[`SSB_FLG_C]);
                alu_res = acv[31:0];
                alu_flags = {acv[31], acv[31:0] == 32'h0, acv[33], acv[32]};
            end
            default:
                alu_hit = 1'b0;
        endcase
    end

    // ****************************************
    // sequencer and register file
    // ****************************************
    wire [3:0] cur_idx = lowest_idx(mask_r);
    wire [15:0] mask_left = mask_r & ~(16'h0001 << cur_idx);
    wire [3:0] nxt_idx = lowest_idx(mask_left);
    wire [3:0] first_idx = lowest_idx(push_mask);

    function [31:0] reg_val;
        input [3:0] idx;
        begin
            if (idx == `SSB_IDX_LINK)
                reg_val = link_r;
            else
                reg_val = low_r[idx[2:0]];
        end
    endfunction

    // event pulses for the sticky status bits, one cycle each
    reg [3:0] set_ev;

    always @*
    begin
        set_ev = 4'h0;
        case (state_r)
            S_IDLE:
            begin
                if (take && (is_pop || is_push) && (start_mask == 16'h0000))
                    set_ev[`SSB_ST_EMPTY] = 1'b1;
                if (take && ((is_pop || is_push) ? (start_mask == 16'h0000) : alu_hit))
                    set_ev[`SSB_ST_DONE] = 1'b1;
            end
            S_CAP:
            begin
                if (cur_idx == `SSB_IDX_PC)
                begin
                    set_ev[`SSB_ST_BRANCH] = mem_rdata[0];
                    set_ev[`SSB_ST_FAULT] = !mem_rdata[0];
                end
                if (mask_left == 16'h0000)
                    set_ev[`SSB_ST_DONE] = 1'b1;
            end
            S_WR:
            begin
                if (mask_left == 16'h0000)
                    set_ev[`SSB_ST_DONE] = 1'b1;
            end
            default:
                set_ev = 4'h0;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            for (k = 0; k < 8; k = k + 1)
                low_r[k] <= `SSB_RST_WORD;
            sp_r <= `SSB_RST_WORD;
            link_r <= `SSB_RST_WORD;
            pc_r <= `SSB_RST_WORD;
            flags_r <= 4'h0;
            state_r <= S_IDLE;
            mask_r <= 16'h0000;
            addr_r <= `SSB_RST_WORD;
            sp_end_r <= `SSB_RST_WORD;
            wdata_r <= `SSB_RST_WORD;
            branch_r <= 1'b0;
            fault_r <= 1'b0;
            status_r <= 4'h0;
            enable_r <= 4'h0;
            rdata_r <= `SSB_RST_WORD;
        end
        else
        begin
            branch_r <= 1'b0;
            fault_r <= 1'b0;
            // software writes; execution below overrides
            if (sw_wr)
            begin
                if (sw_addr < `SSB_OFF_SP && sw_addr[1:0] == 2'b00)
                    low_r[sw_addr[4:2]] <= sw_wdata;
                case (sw_addr)
                    `SSB_OFF_SP: sp_r <= sw_wdata;
                    `SSB_OFF_LINK: link_r <= sw_wdata;
                    `SSB_OFF_FLAGS: flags_r <= sw_wdata[3:0];
                    `SSB_OFF_EN: enable_r <= sw_wdata[3:0];
                    default: ;
                endcase
            end
            case (state_r)
                S_IDLE:
                begin
                    if (take && (is_pop || is_push))
                    begin
                        mask_r <= start_mask;
                        if (start_mask == 16'h0000)
                        begin
                            // no defined result; finish with no access
                            state_r <= S_IDLE;
                        end
                        else if (is_pop)
                        begin
                            addr_r <= sp_r;
                            sp_end_r <= sp_r + span;
                            state_r <= S_RD;
                        end
                        else
                        begin
                            addr_r <= sp_r - span;
                            sp_end_r <= sp_r - span;
                            wdata_r <= reg_val(first_idx);
                            state_r <= S_WR;
                        end
                    end
                    else if (take && alu_hit)
                    begin
                        low_r[rd_idx] <= alu_res;
                        if (set_flags && (op10 != `SSB_OP_WSWAP) &&
                            (op10 != `SSB_OP_HSWAP) && (op10 != `SSB_OP_SSWAP))
                            flags_r <= alu_flags;
                    end
                end
                S_RD:
                    state_r <= S_CAP;
                S_CAP:
                begin
                    if (cur_idx == `SSB_IDX_PC)
                    begin
                        pc_r <= mem_rdata;
                        if (mem_rdata[0])
                        begin
                            branch_r <= 1'b1;
                        end
                        else
                        begin
                            fault_r <= 1'b1;
                        end
                    end
                    else
                        low_r[cur_idx[2:0]] <= mem_rdata;
                    mask_r <= mask_left;
                    addr_r <= addr_r + `SSB_WORD_STEP;
                    if (mask_left == 16'h0000)
                    begin
                        sp_r <= sp_end_r;
                        state_r <= S_IDLE;
                    end
                    else
                        state_r <= S_RD;
                end
                S_WR:
                begin
                    mask_r <= mask_left;
                    addr_r <= addr_r + `SSB_WORD_STEP;
                    wdata_r <= reg_val(nxt_idx);
                    if (mask_left == 16'h0000)
                    begin
                        sp_r <= sp_end_r;
                        state_r <= S_IDLE;
                    end
                end
                default:
                    state_r <= S_IDLE;
            endcase
            // new events win over a clear in the same cycle
            if (sw_wr && sw_addr == `SSB_OFF_CLR)
                status_r <= (status_r & ~sw_wdata[3:0]) | set_ev;
            else
                status_r <= status_r | set_ev;
            // read data stands only in the cycle after the strobe
            if (sw_rd)
            begin
                if (sw_addr < `SSB_OFF_SP && sw_addr[1:0] == 2'b00)
                    rdata_r <= low_r[sw_addr[4:2]];
                else
                begin
                    case (sw_addr)
                        `SSB_OFF_SP: rdata_r <= sp_r;
                        `SSB_OFF_LINK: rdata_r <= link_r;
                        `SSB_OFF_PC: rdata_r <= pc_r;
                        `SSB_OFF_FLAGS: rdata_r <= {28'h0, flags_r};
                        `SSB_OFF_STAT: rdata_r <= {28'h0, status_r};
                        `SSB_OFF_EN: rdata_r <= {28'h0, enable_r};
                        default: rdata_r <= `SSB_RST_WORD;
                    endcase
                end
            end
            else
                rdata_r <= `SSB_RST_WORD;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign instr_ready = state_r == S_IDLE;
    assign busy = state_r != S_IDLE;
    assign mem_addr = addr_r;
    assign mem_rd = state_r == S_RD;
    assign mem_wr = state_r == S_WR;
    assign mem_wdata = wdata_r;
    assign branch_valid = branch_r;
    assign branch_target = pc_r;
    assign hard_fault = fault_r;
    assign sw_rdata = rdata_r;
    assign irq = |(status_r & enable_r);

endmodule

/* sim/ssb_exec_checker.sv */
// Purpose: port assertions for the stack and swap executor
// Assumes: one clock, synchronous reset
// Notes: sees the top ports only
`timescale 1ns/100ps
`include "ssb_exec_map.vh"
module ssb_exec_checker (
    // clock and reset
    input wire clk,
    input wire reset,
    // issue and stack bus
    input wire instr_valid,
    input wire [15:0] instr,
    input wire instr_ready,
    input wire [31:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    // events and software port
    input wire branch_valid,
    input wire [31:0] branch_target,
    input wire hard_fault,
    input wire busy,
    input wire sw_rd,
    input wire [31:0] sw_rdata
);
    default clocking dclk @(posedge clk);
    endclocking
    default disable iff (reset);
    // ****************************************
    // stack sequences
    // ****************************************
    sequence take_pop;
        instr_valid && instr_ready && instr[15:9] == `SSB_OP_POP && |instr[8:0];
    endsequence
    sequence take_push;
        instr_valid && instr_ready && instr[15:9] == `SSB_OP_PUSH && |instr[8:0];
    endsequence
    // a gap cycle inside one pop keeps the next pop's first read out
    sequence read_gap;
        mem_rd ##1 (busy && !mem_rd) ##1 mem_rd;
    endsequence
    a_pop_first_read: assert property (take_pop |=> mem_rd && busy)
        else $error("pop did not start reading");
    a_push_first_write: assert property (take_push |=> mem_wr && busy)
        else $error("push did not start writing");
    a_pop_read_step: assert property (read_gap |-> mem_addr == $past(mem_addr, 2) + 32'h4)
        else $error("pop address not ascending by four");
    a_push_write_step: assert property (mem_wr ##1 mem_wr |-> mem_addr == $past(mem_addr) + 32'h4)
        else $error("push address not ascending by four");
    a_branch_odd_target: assert property (branch_valid |-> branch_target[0] && !hard_fault)
        else $error("branch taken on even target");
    a_pulse_after_read: assert property (branch_valid || hard_fault |-> $past(mem_rd, 2))
        else $error("pc outcome not two cycles after last read");
    a_busy_blocks_issue: assert property (busy |-> !instr_ready)
        else $error("ready while busy");
    a_rdata_idle_zero: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
        else $error("read data outside answer cycle");
endmodule
bind ssb_exec ssb_exec_checker chk_u (
    .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .branch_valid(branch_valid), .branch_target(branch_target), .hard_fault(hard_fault),
    .busy(busy), .sw_rd(sw_rd), .sw_rdata(sw_rdata)
);

/* sim/ssb_stack_mem.sv */
// Purpose: stack memory model on the word bus
// Assumes: read word due in the cycle after the strobe
// Notes: holds 256 words
`timescale 1ns/100ps
module ssb_stack_mem (
    // clock
    input wire clk,
    // word bus
    input wire [31:0] mem_addr,
    input wire mem_rd,
    input wire mem_wr,
    input wire [31:0] mem_wdata,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    initial mem_rdata = 32'h0;
    always @(posedge clk)
    begin
        if (mem_wr)
            mem[mem_addr[9:2]] <= mem_wdata;
        // toggles when idle so a late capture is caught
        if (mem_rd)
            mem_rdata <= mem[mem_addr[9:2]];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule

/* sim/stack_multi_and_byteswap_exec_tb.sv */
// Purpose: random and corner tests of the executor
// Assumes: registers reached over the software port
// Notes: expectations come from alu and the stack loop
`timescale 1ns/100ps
`include "ssb_exec_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module stack_multi_and_byteswap_exec_tb;
    logic clk, reset, instr_valid, instr_in_cblock, sw_wr, sw_rd, bv, hf;
    logic instr_ready, mem_rd, mem_wr, branch_valid, hard_fault, busy, irq;
    logic [15:0] instr;
    logic [7:0] sw_addr, m;
    logic [31:0] sw_wdata, mem_rdata, mem_addr, mem_wdata, branch_target, sw_rdata;
    logic [31:0] rd, a, b, lr, sp;
    logic [31:0] rv [0:7];
    logic [35:0] e;
    logic [3:0] f;
    logic [9:0] opc [0:5] = '{`SSB_OP_WSWAP, `SSB_OP_HSWAP, `SSB_OP_SSWAP, `SSB_OP_ROTR,
        `SSB_OP_RSUB, `SSB_OP_SUBC};
    logic [7:0] amt [0:3] = '{8'h00, 8'h20, 8'h40, 8'hff};
    integer fail_count, checked, seed, i, k, n, cnt;
    ssb_exec dut_u (.clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
        .instr_in_cblock(instr_in_cblock), .instr_ready(instr_ready), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .branch_valid(branch_valid), .branch_target(branch_target), .hard_fault(hard_fault),
        .busy(busy), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq(irq));
    ssb_stack_mem mem_u (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ****************************************
    // bus tasks and model
    // ****************************************
    task sw_write(input [7:0] ad, input [31:0] d);
        @(posedge clk);
        sw_wr <= 1'b1;
        sw_addr <= ad;
        sw_wdata <= d;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task sw_read(input [7:0] ad, output [31:0] d);
        @(posedge clk);
        sw_rd <= 1'b1;
        sw_addr <= ad;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1;
        d = sw_rdata;
    endtask
    task exec(input [15:0] ins, input cb);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr <= ins;
        instr_in_cblock <= cb;
        @(posedge clk);
        instr_valid <= 1'b0;
        #1;
        n = 0;
        while (instr_ready !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        // pc pop pulses stand only in the cycle ready returns
        bv = branch_valid;
        hf = hard_fault;
        `CHK("ready back", 1'b1, instr_ready)
    endtask
    function automatic [35:0] alu(input [2:0] op, input [31:0] x, y, input [3:0] fl,
        input cb);
        logic [32:0] s;
        logic [31:0] r, xa, yb;
        logic [3:0] fo;
        case (op)
            3'd0: r = {y[7:0], y[15:8], y[23:16], y[31:24]};
            3'd1: r = {y[23:16], y[31:24], y[7:0], y[15:8]};
            3'd2: r = {{16{y[7]}}, y[7:0], y[15:8]};
            3'd3: r = (x >> y[4:0]) | (x << (6'd32 - y[4:0]));
            default:
            begin
                xa = (op == 3'd4) ? ~y : x;
                yb = (op == 3'd4) ? 32'h0 : ~y;
                s = {1'b0, xa} + {1'b0, yb} + ((op == 3'd4) ? 33'h1 : {32'h0, fl[1]});
                r = s[31:0];
            end
        endcase
        fo = {r[31], r == 32'h0, s[32], xa[31] == yb[31] && r[31] != xa[31]};
        if (op == 3'd3)
            fo = {r[31], r == 32'h0, (y[7:0] != 8'h00) ? r[31] : fl[1], fl[0]};
        // swaps never touch flags
        if (op < 3'd3 || cb)
            fo = fl;
        return {fo, r};
    endfunction
    task results;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        seed = 32'hd1de;
        fail_count = 0;
        checked = 0;
        {reset, instr_valid, instr_in_cblock, sw_wr, sw_rd} = 5'h10;
        {instr, sw_addr, sw_wdata} = 56'h0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        for (i = 0; i < 48; i++)
        begin
            a = $random(seed);
            b = $random(seed);
            f = 4'($random(seed));
            // awkward rotate amounts: zero, whole turns, bottom byte all ones
            if (i < 24 && i % 6 == 3)
                b[7:0] = amt[i / 6];
            if (i == 4)
                b = 32'h8000_0000;
            if (i == 11)
                a = b;
            sw_write(8'h04, a);
            sw_write(8'h08, b);
            sw_write(`SSB_OFF_FLAGS, {28'h0, f});
            exec({opc[i % 6], 3'd2, 3'd1}, i[3]);
            e = alu(3'(i % 6), a, b, f, i[3]);
            sw_read(8'h04, rd);
            `CHK("result", e[31:0], rd)
            sw_read(`SSB_OFF_FLAGS, rd);
            `CHK("flags", e[35:32], rd[3:0])
        end
        for (k = 0; k < 4; k++)
        begin
            m = (k == 0) ? 8'hff : (k == 1) ? 8'h01 : 8'($random(seed));
            // list never empty
            if (m == 8'h00) m = 8'h80;
            lr = $random(seed);
            lr[0] = k[0];
            for (i = 0; i < 8; i++)
            begin
                rv[i] = $random(seed);
                sw_write(8'(i * 4), rv[i]);
            end
            sw_write(`SSB_OFF_LINK, lr);
            sw_write(`SSB_OFF_SP, 32'h100);
            sw_write(`SSB_OFF_EN, 32'h2);
            exec({`SSB_OP_PUSH, 1'b1, m}, 1'b0);
            cnt = $countones(m) + 1;
            sp = 32'h100 - 32'(4 * cnt);
            sw_read(`SSB_OFF_SP, rd);
            `CHK("push sp", sp, rd)
            for (i = 0; i < 8; i++)
                if (m[i])
                begin
                    `CHK("stored", rv[i], mem_u.mem[sp[9:2]])
                    sp += 32'h4;
                end
            `CHK("stored link", lr, mem_u.mem[sp[9:2]])
            for (i = 0; i < 8; i++)
                sw_write(8'(i * 4), 32'h0);
            sw_write(`SSB_OFF_SP, 32'h100 - 32'(4 * cnt));
            sw_write(`SSB_OFF_CLR, 32'hf);
            // pc pop only outside a conditional block
            exec({`SSB_OP_POP, 1'b1, m}, 1'b0);
            `CHK("pulses", {lr[0], ~lr[0]}, {bv, hf})
            `CHK("target", lr, branch_target)
            sw_read(`SSB_OFF_SP, rd);
            `CHK("pop sp", 32'h100, rd)
            for (i = 0; i < 8; i++)
            begin
                sw_read(8'(i * 4), rd);
                `CHK("loaded", m[i] ? rv[i] : 32'h0, rd)
            end
            sw_read(`SSB_OFF_STAT, rd);
            `CHK("status", {lr[0], ~lr[0]}, {rd[3], rd[1]})
            `CHK("irq", ~lr[0], irq)
            sw_write(`SSB_OFF_CLR, 32'hf);
            sw_read(8'h3c, rd);
            `CHK("unmapped", 32'h0, rd)
            `CHK("irq clear", 1'b0, irq)
        end
        results;
    end
endmodule
